// [design/tsrac_pkg.sv]
// Purpose: shared constants and types for the temperature sensor register block
// Assumes: 250 MHz reference clock
// Notes:   pointer values double as register offsets
package tsrac_pkg;

  // pointer values
  localparam logic [7:0]  PTR_TEMP      = 8'h00;
  localparam logic [7:0]  PTR_CFG       = 8'h01;
  localparam logic [7:0]  PTR_UPPER     = 8'h02;
  localparam logic [7:0]  PTR_LOWER     = 8'h03;
  localparam logic [7:0]  PTR_STAT      = 8'h04;

  // reset and special values
  localparam logic [15:0] TEMP_RESET    = 16'h7ffc;
  localparam logic [15:0] TEMP_ONESHOT  = 16'h8000;
  localparam logic [15:0] UPPER_RESET   = 16'h7fe0;
  localparam logic [15:0] LOWER_RESET   = 16'h8000;
  localparam logic [15:0] LIMIT_MASK    = 16'hffe0;
  localparam logic [7:0]  CFG_RESET     = 8'h40;
  localparam logic [1:0]  RES_RESET     = 2'h0;

  // field positions
  localparam int          CFG_PD_BIT    = 7;
  localparam int          CFG_RSV_BIT   = 6;
  localparam int          CFG_DIS_BIT   = 5;
  localparam int          CFG_POL_BIT   = 4;
  localparam int          CFG_CLR_BIT   = 3;
  localparam int          CFG_OS_BIT    = 2;
  localparam int          STAT_RES_LSB  = 5;

  // timing
  localparam int          CLK_PERIOD_PS    = 4000;
  localparam int          CONV_TIME_11B_US = 14000;
  localparam int          CONV_CYCLES_11B  = CONV_TIME_11B_US * (1000000 / CLK_PERIOD_PS);
  localparam int          CONV_CNT_W       = 25;

  // default bus address
  localparam logic [6:0]  SLAVE_ADDR_DEF = 7'h48;

  typedef struct packed {
    logic pd;
    logic rsv6;
    logic ot_dis;
    logic ot_pol;
  } tsrac_cfg_t;

  typedef enum logic [1:0] {
    MODE_RUN      = 2'b00,
    MODE_STOPPING = 2'b01,
    MODE_SHUTDOWN = 2'b10,
    MODE_ONESHOT  = 2'b11
  } tsrac_mode_t;

  typedef enum logic [3:0] {
    BUS_IDLE  = 4'b0000,
    BUS_ADDR  = 4'b0001,
    BUS_AACK  = 4'b0010,
    BUS_PTR   = 4'b0011,
    BUS_PACK  = 4'b0100,
    BUS_WDATA = 4'b0101,
    BUS_WACK  = 4'b0110,
    BUS_RDATA = 4'b0111,
    BUS_RACK  = 4'b1000
  } tsrac_bus_t;

endpackage : tsrac_pkg

// [design/tsrac_conv_timer.sv]
// Purpose: conversion timing, one done pulse per conversion
// Assumes: run_i low resets the count
// Notes:   resolution latched at conversion start
module tsrac_conv_timer #(
  parameter int BASE_CYCLES = tsrac_pkg::CONV_CYCLES_11B,
  parameter int CNT_W       = tsrac_pkg::CONV_CNT_W
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [1:0] res_i,
  output logic            done_o,
  output logic [1:0]      res_used_o
);
  import tsrac_pkg::*;

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] limit;
  logic             active;

  // terminal count doubles per resolution step
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt        <= '0;
      limit      <= '0;
      active     <= 1'b0;
      done_o     <= 1'b0;
      res_used_o <= RES_RESET;
    end else if (!active) begin
      active     <= 1'b1;
      cnt        <= CNT_W'(1);
      limit      <= CNT_W'(BASE_CYCLES) << res_i;
      res_used_o <= res_i;
      done_o     <= 1'b0;
    end else if (cnt == limit) begin
      active     <= 1'b0;
      cnt        <= '0;
      done_o     <= 1'b1;
    end else begin
      cnt        <= cnt + CNT_W'(1);
      done_o     <= 1'b0;
    end
  end

  property p_done_at_limit;
    @(posedge clk_i) disable iff (rst_i)
    done_o |-> ($past(cnt) == $past(limit)) && $past(active) && !active;
  endproperty
  a_done_at_limit: assert property (p_done_at_limit)
    else $error("done without reaching terminal count");

endmodule : tsrac_conv_timer

// [design/tsrac_top.sv]
// Purpose: sensor registers, two-wire slave, over-temperature output
// Assumes: TEMP_SAMPLE_I is a same-clock converter word
// Notes:   bus pins pass two flops before use
//
// How it works
// - result register at 00h, read only
// - result resets to 7FFCh
// - single-shot state reads 8000h until done
// - bits 15:2 hold latest conversion
// - data valid flag set at first conversion
// - resolution select sets result width
// - result bits 1:0 read zero
// - configuration at 01h, resets to 40h
// - power-off bit stops after conversion ends
// - clearing power-off resumes continuous conversion
// - disable bit turns alert output off
// - disable bit also governs pin status bit
// - polarity bit picks active level
// - clear bit deasserts alert, reads zero
// - trigger in shutdown runs one conversion
// - trigger ignored when running, reads zero
// - upper limit at 02h, read/write
// - upper limit resets to 7FE0h
// - above limit asserts alert and flag
// - upper limit bits 4:0 read zero
// - comparisons use top eleven bits only
// - below lower limit clears alert
// - cleared alert returns if still above
// - resolution codes 00 to 11 map 11-14 bits
module tsrac_top #(
  parameter logic [6:0] SLAVE_ADDR  = tsrac_pkg::SLAVE_ADDR_DEF,
  parameter int         CONV_CYCLES = tsrac_pkg::CONV_CYCLES_11B
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        RST_I,
  input  wire logic        SCL_I,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_O,
  input  wire logic [15:0] TEMP_SAMPLE_I,
  output logic             OVERTEMP_O
);
  import tsrac_pkg::*;

  function automatic logic [15:0] res_mask(input logic [1:0] res);
    logic signed [15:0] m;
    m        = LIMIT_MASK;
    res_mask = m >>> res;
  endfunction : res_mask

  function automatic logic ptr_valid(input logic [7:0] p);
    ptr_valid = (p <= PTR_STAT);
  endfunction : ptr_valid

  logic             scl_meta, scl_sync, scl_prev;
  logic             sda_meta, sda_sync, sda_prev;
  logic             scl_rise, scl_fall, start_cond, stop_cond;
  tsrac_bus_t       bus_state;
  logic [3:0]       bit_cnt;
  logic [7:0]       shift;
  logic             rw;
  logic [7:0]       ptr;
  logic [1:0]       byte_idx;
  logic             mnack;
  logic [7:0]       lsb_hold;
  logic             wr_stb;
  logic [7:0]       wr_byte;
  logic [1:0]       wr_idx;
  logic             stat_read;
  logic [15:0]      rd_word;
  logic             rd_is8;
  logic [7:0]       wr_msb;
  tsrac_cfg_t       cfg;
  logic [1:0]       res;
  logic [15:0]      upper;
  logic [15:0]      lower;
  logic [15:0]      temp_result;
  tsrac_mode_t      mode;
  logic             cfg_wr, ot_clear, os_req, enter_os;
  logic             conv_done;
  logic [1:0]       conv_res;
  logic [15:0]      sample_m;
  logic             above_now, below_now;
  logic             stat_dv, above_flag, below_flag, last_above, last_below;
  logic             ot_active;

  // pin synchronisers
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= SCL_I;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= SDA_I;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  assign scl_rise   = scl_sync & ~scl_prev;
  assign scl_fall   = ~scl_sync & scl_prev;
  assign start_cond = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_cond  = scl_sync & scl_prev & ~sda_prev & sda_sync;

  // read mux
  always_comb begin
    rd_is8 = 1'b0;
    unique case (ptr)
      PTR_CFG: begin
        rd_word = {8'h00, cfg.pd, cfg.rsv6, cfg.ot_dis, cfg.ot_pol, 4'h0};
        rd_is8  = 1'b1;
      end
      PTR_UPPER: rd_word = upper;
      PTR_LOWER: rd_word = lower;
      PTR_STAT: begin
        rd_word = {8'h00, 1'b0, res, 1'b0, OVERTEMP_O, above_flag, below_flag, stat_dv};
        rd_is8  = 1'b1;
      end
      default: rd_word = temp_result;
    endcase
  end

  // two-wire slave
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      bus_state <= BUS_IDLE;
      bit_cnt   <= 4'h0;
      shift     <= 8'h00;
      rw        <= 1'b0;
      ptr       <= PTR_TEMP;
      byte_idx  <= 2'h0;
      mnack     <= 1'b0;
      lsb_hold  <= 8'h00;
      wr_stb    <= 1'b0;
      wr_byte   <= 8'h00;
      wr_idx    <= 2'h0;
      stat_read <= 1'b0;
      SDA_OE_O  <= 1'b0;
    end else begin
      wr_stb    <= 1'b0;
      stat_read <= 1'b0;
      if (start_cond) begin
        bus_state <= BUS_ADDR;
        bit_cnt   <= 4'h0;
        SDA_OE_O  <= 1'b0;
      end else if (stop_cond) begin
        bus_state <= BUS_IDLE;
        SDA_OE_O  <= 1'b0;
      end else if (scl_rise) begin
        if (bus_state == BUS_ADDR || bus_state == BUS_PTR || bus_state == BUS_WDATA) begin
          shift   <= {shift[6:0], sda_sync};
          bit_cnt <= bit_cnt + 4'h1;
        end else if (bus_state == BUS_RDATA) begin
          bit_cnt <= bit_cnt + 4'h1;
        end else if (bus_state == BUS_RACK) begin
          mnack   <= sda_sync;
        end
      end else if (scl_fall) begin
        unique case (bus_state)
          BUS_IDLE: SDA_OE_O <= 1'b0;
          BUS_ADDR: if (bit_cnt == 4'h8) begin
            if (shift[7:1] == SLAVE_ADDR) begin
              SDA_OE_O  <= 1'b1;
              rw        <= shift[0];
              bus_state <= BUS_AACK;
            end else begin
              bus_state <= BUS_IDLE;
            end
          end
          BUS_AACK: begin
            bit_cnt  <= 4'h0;
            byte_idx <= 2'h0;
            if (rw) begin
              shift     <= rd_is8 ? rd_word[7:0] : rd_word[15:8];
              lsb_hold  <= rd_word[7:0];
              SDA_OE_O  <= rd_is8 ? ~rd_word[7] : ~rd_word[15];
              stat_read <= (ptr == PTR_STAT);
              bus_state <= BUS_RDATA;
            end else begin
              SDA_OE_O  <= 1'b0;
              bus_state <= BUS_PTR;
            end
          end
          BUS_PTR: if (bit_cnt == 4'h8) begin
            if (ptr_valid(shift)) begin
              ptr       <= shift;
              SDA_OE_O  <= 1'b1;
              bus_state <= BUS_PACK;
            end else begin
              bus_state <= BUS_IDLE;
            end
          end
          BUS_PACK: begin
            SDA_OE_O  <= 1'b0;
            bit_cnt   <= 4'h0;
            bus_state <= BUS_WDATA;
          end
          BUS_WDATA: if (bit_cnt == 4'h8) begin
            SDA_OE_O  <= 1'b1;
            wr_stb    <= 1'b1;
            wr_byte   <= shift;
            wr_idx    <= byte_idx;
            bus_state <= BUS_WACK;
          end
          BUS_WACK: begin
            SDA_OE_O  <= 1'b0;
            bit_cnt   <= 4'h0;
            byte_idx  <= (byte_idx == 2'h2) ? 2'h2 : byte_idx + 2'h1;
            bus_state <= BUS_WDATA;
          end
          BUS_RDATA: begin
            if (bit_cnt == 4'h8) begin
              SDA_OE_O  <= 1'b0;
              bus_state <= BUS_RACK;
            end else begin
              SDA_OE_O  <= ~shift[6];
              shift     <= {shift[6:0], 1'b0};
            end
          end
          BUS_RACK: begin
            bit_cnt <= 4'h0;
            if (mnack) begin
              bus_state <= BUS_IDLE;
            end else begin
              shift     <= rd_is8 ? rd_word[7:0] : lsb_hold;
              SDA_OE_O  <= rd_is8 ? ~rd_word[7] : ~lsb_hold[7];
              byte_idx  <= 2'h1;
              bus_state <= BUS_RDATA;
            end
          end
          default: begin
            SDA_OE_O  <= 1'b0;
            bus_state <= BUS_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    SDA_O <= 1'b0;
  end

  assign cfg_wr   = wr_stb && ptr == PTR_CFG && wr_idx == 2'h0;
  assign ot_clear = cfg_wr && wr_byte[CFG_CLR_BIT];
  assign os_req   = cfg_wr && wr_byte[CFG_OS_BIT] && wr_byte[CFG_PD_BIT];
  assign enter_os = os_req && mode == MODE_SHUTDOWN;

  // writable registers
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      cfg    <= tsrac_cfg_t'(CFG_RESET[7:4]);
      res    <= RES_RESET;
      upper  <= UPPER_RESET;
      lower  <= LOWER_RESET;
      wr_msb <= 8'h00;
    end else if (wr_stb) begin
      if (wr_idx == 2'h0) begin
        wr_msb <= wr_byte;
      end
      if (cfg_wr) begin
        cfg <= tsrac_cfg_t'(wr_byte[7:4]);
      end
      if (ptr == PTR_STAT && wr_idx == 2'h0) begin
        res <= wr_byte[STAT_RES_LSB +: 2];
      end
      if (ptr == PTR_UPPER && wr_idx == 2'h1) begin
        upper <= {wr_msb, wr_byte} & LIMIT_MASK;
      end
      if (ptr == PTR_LOWER && wr_idx == 2'h1) begin
        lower <= {wr_msb, wr_byte} & LIMIT_MASK;
      end
    end
  end

  // conversion mode
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      mode <= MODE_RUN;
    end else begin
      unique case (mode)
        MODE_RUN:      if (cfg.pd) mode <= MODE_STOPPING;
        MODE_STOPPING: if (!cfg.pd) mode <= MODE_RUN;
                       else if (conv_done) mode <= MODE_SHUTDOWN;
        MODE_SHUTDOWN: if (!cfg.pd) mode <= MODE_RUN;
                       else if (enter_os) mode <= MODE_ONESHOT;
        MODE_ONESHOT:  if (!cfg.pd) mode <= MODE_RUN;
                       else if (conv_done) mode <= MODE_SHUTDOWN;
      endcase
    end
  end

  tsrac_conv_timer #(
    .BASE_CYCLES (CONV_CYCLES),
    .CNT_W       (CONV_CNT_W)
  ) u_timer (
    .clk_i      (REF_CLK_I),
    .rst_i      (RST_I),
    .run_i      (mode != MODE_SHUTDOWN),
    .res_i      (res),
    .done_o     (conv_done),
    .res_used_o (conv_res)
  );

  assign sample_m  = TEMP_SAMPLE_I & res_mask(conv_res);
  assign above_now = $signed(sample_m[15:5]) > $signed(upper[15:5]);
  assign below_now = $signed(sample_m[15:5]) < $signed(lower[15:5]);

  // result register
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      temp_result <= TEMP_RESET;
    end else if (conv_done) begin
      temp_result <= sample_m;
    end else if (enter_os) begin
      temp_result <= TEMP_ONESHOT;
    end
  end

  // flags and alert
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      stat_dv    <= 1'b0;
      above_flag <= 1'b0;
      below_flag <= 1'b0;
      last_above <= 1'b0;
      last_below <= 1'b0;
      ot_active  <= 1'b0;
    end else begin
      if (conv_done) begin
        stat_dv    <= 1'b1;
        last_above <= above_now;
        last_below <= below_now;
      end
      if (conv_done && above_now) begin
        above_flag <= 1'b1;
      end else if (stat_read && !last_above) begin
        above_flag <= 1'b0;
      end
      if (conv_done && below_now) begin
        below_flag <= 1'b1;
      end else if (stat_read && !last_below) begin
        below_flag <= 1'b0;
      end
      if (conv_done && above_now) begin
        ot_active <= 1'b1;
      end else if ((conv_done && below_now) || ot_clear) begin
        ot_active <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      OVERTEMP_O <= 1'b1;
    end else begin
      OVERTEMP_O <= (ot_active && !cfg.ot_dis) ? cfg.ot_pol : !cfg.ot_pol;
    end
  end

  property p_reset_value;
    @(posedge REF_CLK_I) disable iff (RST_I)
    (!stat_dv && mode != MODE_ONESHOT) |-> temp_result == TEMP_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("result left reset value before first conversion");

  property p_oneshot_value;
    @(posedge REF_CLK_I) disable iff (RST_I)
    (mode == MODE_ONESHOT && !$past(conv_done)) |-> temp_result == TEMP_ONESHOT;
  endproperty
  a_oneshot_value: assert property (p_oneshot_value)
    else $error("single-shot state does not read 8000h");

  property p_result_update;
    @(posedge REF_CLK_I) disable iff (RST_I)
    conv_done |=> temp_result == $past(sample_m) && temp_result[1:0] == 2'b00 && stat_dv;
  endproperty
  a_result_update: assert property (p_result_update)
    else $error("result not updated from conversion");

  property p_result_hold;
    @(posedge REF_CLK_I) disable iff (RST_I)
    (!conv_done && !enter_os) |=> $stable(temp_result);
  endproperty
  a_result_hold: assert property (p_result_hold)
    else $error("result changed without conversion");

  property p_above_sets;
    @(posedge REF_CLK_I) disable iff (RST_I)
    (conv_done && above_now) |=> ot_active && above_flag;
  endproperty
  a_above_sets: assert property (p_above_sets)
    else $error("alert not raised above upper limit");

  property p_clear_alert;
    @(posedge REF_CLK_I) disable iff (RST_I)
    ((ot_clear || (conv_done && below_now)) && !(conv_done && above_now)) |=> !ot_active;
  endproperty
  a_clear_alert: assert property (p_clear_alert)
    else $error("alert not cleared");

  property p_pin_level;
    @(posedge REF_CLK_I) disable iff (RST_I)
    ##1 OVERTEMP_O == (($past(ot_active) && !$past(cfg.ot_dis)) ? $past(cfg.ot_pol) : !$past(cfg.ot_pol));
  endproperty
  a_pin_level: assert property (p_pin_level)
    else $error("alert pin level wrong");

  property p_trigger_ignored;
    @(posedge REF_CLK_I) disable iff (RST_I)
    (cfg_wr && wr_byte[CFG_OS_BIT] && mode != MODE_SHUTDOWN) |=> mode != MODE_ONESHOT && ($stable(temp_result) || $past(conv_done));
  endproperty
  a_trigger_ignored: assert property (p_trigger_ignored)
    else $error("trigger acted in continuous mode");

  property p_wake;
    @(posedge REF_CLK_I) disable iff (RST_I)
    (!cfg.pd && mode != MODE_RUN) |=> mode == MODE_RUN;
  endproperty
  a_wake: assert property (p_wake)
    else $error("did not resume continuous conversion");

endmodule : tsrac_top

// [dv/tsrac_host.sv]
// Purpose: two-wire bus host model
// Assumes: open-drain data line, pull-up in the bench
// Notes:   32 ns bit period, slow_i stretches the low phase
module tsrac_host (
  input  wire logic       clk_i,
  input  wire logic       sda_i,
  input  wire logic       slow_i,
  output logic            scl_o,
  output logic            sda_low_o,
  output logic [7:0]      res_o,
  output logic            stb_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int Q = 8;
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
    res_o     = 8'h00;
    stb_o     = 1'b0;
  end
  task automatic post(input logic [7:0] v);
    res_o = v;
    stb_o = 1'b1;
    fork
      #1 stb_o = 1'b0;
    join_none
  endtask : post
  task automatic start();
    @(posedge clk_i);
    #1;
    sda_low_o = 1'b0;
    #(2 * Q);
    scl_o = 1'b1;
    #Q;
    sda_low_o = 1'b1;
    #Q;
    scl_o = 1'b0;
    #Q;
  endtask : start
  task automatic stop();
    sda_low_o = 1'b1;
    #Q;
    scl_o = 1'b1;
    #Q;
    sda_low_o = 1'b0;
    #(2 * Q);
  endtask : stop
  task automatic put(input logic b);
    sda_low_o = !b;
    #(slow_i ? 4 * Q : Q);
    scl_o = 1'b1;
    #(2 * Q);
    scl_o = 1'b0;
    #Q;
  endtask : put
  task automatic get(output logic b);
    sda_low_o = 1'b0;
    #Q;
    scl_o = 1'b1;
    #Q;
    b = sda_i;
    #Q;
    scl_o = 1'b0;
    #Q;
  endtask : get
  task automatic wbyte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(a);
    post({7'h00, a});
  endtask : wbyte
  task automatic rbyte(input logic nack);
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(nack);
    post(d);
  endtask : rbyte
endmodule : tsrac_host

// [dv/tb.sv]
// Purpose: self-checking bench for the sensor register block
// Assumes: host model drives the two-wire bus
// Notes:   short conversion time for speed
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tsrac_pkg::*;
  `define CHK(G, E) begin total_checks++; if ((G) !== (E)) begin mismatches++; \
    $display("[ERR] %0t got %h exp %h", $time, G, E); end end
  localparam int         CC = 600;
  localparam logic [7:0] AW = {SLAVE_ADDR_DEF, 1'b0};
  localparam logic [7:0] AR = {SLAVE_ADDR_DEF, 1'b1};
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        slow    = 1'b0;
  logic        pin_stb = 1'b0;
  logic [15:0] smp     = 16'h1234;
  logic        scl, sda_low, sda_o, sda_oe, ot, stb;
  logic [7:0]  res;
  logic [7:0]  exp_q[$];
  int          mismatches = 0;
  int          total_checks = 0;
  wire logic   sda = sda_low ? 1'b0 : (sda_oe ? sda_o : 1'b1);
  always #2 ref_clk = ~ref_clk;
  tsrac_top #(.CONV_CYCLES(CC)) u_tsrac_top (.REF_CLK_I(ref_clk), .RST_I(rst), .SCL_I(scl),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .TEMP_SAMPLE_I(smp), .OVERTEMP_O(ot));
  tsrac_host u_tsrac_host (.clk_i(ref_clk), .sda_i(sda), .slow_i(slow), .scl_o(scl),
    .sda_low_o(sda_low), .res_o(res), .stb_o(stb));
  // oldest expectation against each result
  always @(posedge stb or posedge pin_stb) begin
    logic [7:0] e;
    logic [7:0] g;
    e = exp_q.pop_front();
    g = (stb === 1'b1) ? res : {7'h00, ot};
    `CHK(g, e)
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic conv(input int r);
    cyc(2 * ((CC << r) + 1) + 20);
  endtask : conv
  task automatic pin(input logic v);
    exp_q.push_back({7'h00, v});
    pin_stb = 1'b1;
    cyc(1);
    pin_stb = 1'b0;
  endtask : pin
  task automatic wb(input logic [7:0] e, input logic [7:0] d);
    exp_q.push_back(e);
    u_tsrac_host.wbyte(d);
  endtask : wb
  task automatic rb(input logic [7:0] e, input logic nack);
    exp_q.push_back(e);
    u_tsrac_host.rbyte(nack);
  endtask : rb
  task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n, input logic pn);
    u_tsrac_host.start();
    wb(8'h00, AW);
    wb({7'h00, pn}, p);
    if (n == 2) wb(8'h00, d[15:8]);
    if (n > 0) wb(8'h00, d[7:0]);
    u_tsrac_host.stop();
  endtask : wr
  task automatic rd(input logic [7:0] p, input logic [15:0] e, input int n, input logic set);
    u_tsrac_host.start();
    if (set) begin
      wb(8'h00, AW);
      wb(8'h00, p);
      u_tsrac_host.start();
    end
    wb(8'h00, AR);
    if (n == 2) rb(e[15:8], 1'b0);
    rb(e[7:0], 1'b1);
    u_tsrac_host.stop();
  endtask : rd
  task automatic fin_test(input string s);
    $display("test %s done", s);
  endtask : fin_test
  initial begin
    #400000;
    mismatches++;
    close_out();
  end
  initial begin
    int r;
    logic [15:0] old;
    void'($urandom(32'h4431));
    cyc(5);
    rst = 1'b0;
    cyc(4);
    rd(PTR_TEMP, TEMP_RESET, 2, 1'b1);
    rd(PTR_CFG, {8'h00, CFG_RESET}, 1, 1'b1);
    rd(PTR_UPPER, UPPER_RESET, 2, 1'b1);
    conv(0);
    rd(PTR_STAT, 16'h0009, 1, 1'b1);
    pin(1'b1);
    fin_test("reset");
    smp = 16'($urandom()) & 16'h7fff;
    slow = 1'b1;
    conv(0);
    rd(PTR_TEMP, smp & 16'hffe0, 2, 1'b1);
    wr(PTR_TEMP, ~smp, 2, 1'b0);
    rd(PTR_TEMP, smp & 16'hffe0, 2, 1'b1);
    wr(8'h05, 16'h0000, 0, 1'b1);
    rd(PTR_TEMP, smp & 16'hffe0, 2, 1'b0);
    slow = 1'b0;
    fin_test("result");
    for (r = 0; r < 4; r++) begin
      wr(PTR_STAT, {9'h000, r[1:0], 5'h00}, 1, 1'b0);
      smp = 16'($urandom());
      conv(r);
      rd(PTR_TEMP, smp & (16'hffff << (5 - r)), 2, 1'b1);
    end
    fin_test("resolution");
    wr(PTR_UPPER, 16'h191f, 2, 1'b0);
    rd(PTR_UPPER, 16'h1900, 2, 1'b1);
    smp = 16'h191c;
    conv(3);
    rd(PTR_TEMP, 16'h191c, 2, 1'b1);
    pin(1'b1);
    wr(PTR_STAT, 16'h0000, 1, 1'b0);
    smp = 16'h1920;
    conv(3);
    pin(1'b0);
    rd(PTR_STAT, 16'h0005, 1, 1'b1);
    wr(PTR_CFG, 16'h0050, 1, 1'b0);
    cyc(4);
    pin(1'b1);
    wr(PTR_CFG, 16'h0070, 1, 1'b0);
    cyc(4);
    pin(1'b0);
    wr(PTR_CFG, 16'h0050, 1, 1'b0);
    cyc(4);
    pin(1'b1);
    smp = 16'h1900;
    wr(PTR_CFG, 16'h0058, 1, 1'b0);
    cyc(4);
    pin(1'b0);
    rd(PTR_CFG, 16'h0050, 1, 1'b1);
    smp = 16'h1920;
    conv(0);
    pin(1'b1);
    wr(PTR_LOWER, 16'h1000, 2, 1'b0);
    smp = 16'h0f00;
    conv(0);
    pin(1'b0);
    rd(PTR_STAT, 16'h0007, 1, 1'b1);
    rd(PTR_STAT, 16'h0003, 1, 1'b0);
    fin_test("alert");
    wr(PTR_CFG, 16'h00c0, 1, 1'b0);
    conv(0);
    old = smp & 16'hffe0;
    smp = 16'($urandom());
    conv(0);
    rd(PTR_TEMP, old, 2, 1'b1);
    wr(PTR_CFG, 16'h00c4, 1, 1'b0);
    rd(PTR_TEMP, TEMP_ONESHOT, 2, 1'b1);
    conv(0);
    rd(PTR_TEMP, smp & 16'hffe0, 2, 1'b1);
    wr(PTR_CFG, 16'h0040, 1, 1'b0);
    smp = 16'($urandom());
    conv(0);
    rd(PTR_TEMP, smp & 16'hffe0, 2, 1'b1);
    wr(PTR_CFG, 16'h0044, 1, 1'b0);
    rd(PTR_TEMP, smp & 16'hffe0, 2, 1'b1);
    rd(PTR_CFG, 16'h0040, 1, 1'b1);
    fin_test("shutdown");
    close_out();
  end
endmodule : tb
